// file: hw/ioc_cfg.svh
// Constants of the inspection drive controller.
`ifndef IOC_CFG_SVH
`define IOC_CFG_SVH

`define IOC_CLK_NS         5
`define IOC_TICK_NS        1000000
`define IOC_TICK_CYCLES    (`IOC_TICK_NS / `IOC_CLK_NS)
`define IOC_HOLD_MS        10000
`define IOC_BUZZ_MS        1000
`define IOC_NORMAL_CLR_MS  600000
`define IOC_TMR_W          20

`define IOC_ADDR_W         12
`define IOC_ADDR_CTRL      12'h000
`define IOC_ADDR_CMD       12'h004
`define IOC_ADDR_TOP_DIST  12'h008
`define IOC_ADDR_BOT_DIST  12'h00c
`define IOC_ADDR_STATUS    12'h010

`define IOC_CTRL_RST       32'h0000_0000
`define IOC_DIST_RST       32'h0000_0000
`define IOC_CTRL_PIT_USED  0
`define IOC_CTRL_PIT_UI_OK 1
`define IOC_CTRL_INS_FAST  2
`define IOC_CTRL_RES_FAST  3
`define IOC_CTRL_RES_NOCHN 4
`define IOC_CTRL_BEYOND    5
`define IOC_CTRL_MAN_DOOR  6
`define IOC_CTRL_BUZZ_FIT  7
`define IOC_CTRL_SRC_TOP   8
`define IOC_CTRL_SRC_RES   9
`define IOC_CTRL_W         10
`define IOC_CMD_PIT_RST    0

`define IOC_ST_MODE_LO     0
`define IOC_ST_SPEED_LO    2
`define IOC_ST_UP          4
`define IOC_ST_DOWN        5
`define IOC_ST_PIT_LATCH   6
`define IOC_ST_BLOCKED     7
`define IOC_ST_DOOR_MODE   8
`define IOC_ST_BUZZ        9
`define IOC_ST_CHAIN       10

`endif

// file: hw/ioc_hold_timer.sv
// Millisecond timer that reports once a run request has lasted LIMIT ticks.
`timescale 1ns/1ps
module ioc_hold_timer #(
	parameter int LIMIT = 1000,
	parameter int W     = 20
) (
	input wire logic pclk,    // System clock.
	input wire logic presetn, // Asynchronous reset, active low.
	ioc_tmr_if.timer t        // Run, tick and done.
);
	logic [W-1:0] cnt;

	initial begin
		if (LIMIT < 1 || LIMIT >= (1 << W)) $error("ioc_hold_timer: LIMIT does not fit W");
	end

	// The count saturates at the limit, so done stays high while run is held.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (!t.run) begin
			cnt <= '0;
		end else if (t.tick && cnt != W'(LIMIT)) begin
			cnt <= cnt + W'(1);
		end
	end

	assign t.done = t.run && (cnt == W'(LIMIT));
endmodule

// file: hw/ioc_inspection_ctrl.sv
// Inspection, pit inspection and rescue drive controller with its APB registers.
// Operation
// RQ1 - Three panels: enable, up, down, fast.
// RQ2 - Car top panel: board or first bus only.
// RQ3 - Rescue panel: board or first bus only.
// RQ4 - Pit panel used once blocks until reset.
// RQ5 - Policy decides whether display may clear block.
// RQ6 - Inspection fast fitted: fast speed, else creep.
// RQ7 - Rescue fast fitted: rescue speed, else creep.
// RQ8 - Rescue may ignore passive chain input.
// RQ9 - Beyond-terminal flag clears after normal running.
// RQ10 - Ten second two-button hold swaps to doors.
// RQ11 - Role change sounds fitted buzzer one second.
// RQ12 - Repeat hold or toggle switch restores direction.
// RQ13 - Inspection stops short by configured distances.
// RQ14 - Activation opens chain; direction buttons close it.
// RQ15 - Enabled mode without button commands standstill.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "ioc_cfg.svh"
module ioc_inspection_ctrl
	import ioc_pkg::*;
#(
	parameter int TICK_CYCLES   = `IOC_TICK_CYCLES,
	parameter int HOLD_MS       = `IOC_HOLD_MS,
	parameter int BUZZ_MS       = `IOC_BUZZ_MS,
	parameter int NORMAL_CLR_MS = `IOC_NORMAL_CLR_MS,
	parameter int POS_W         = 24
) (
	input  wire logic                   pclk,             // System clock, 200 MHz.
	input  wire logic                   presetn,          // Asynchronous reset, active low.
	input  wire logic                   psel,             // APB select.
	input  wire logic                   penable,          // APB access phase.
	input  wire logic                   pwrite,           // APB write.
	input  wire logic [`IOC_ADDR_W-1:0] paddr,            // APB byte address.
	input  wire logic [31:0]            pwdata,           // APB write data.
	output logic      [31:0]            prdata,           // APB read data.
	output logic                        pready,           // APB ready.
	output logic                        pslverr,          // APB error.
	input  wire ioc_panel_t             car_top_board,    // Car top panel, board inputs.
	input  wire ioc_panel_t             car_top_bus,      // Car top panel, first_field_bus unit.
	input  wire ioc_panel_t             pit_panel,        // Pit panel.
	input  wire ioc_panel_t             rescue_board,     // Rescue panel, board inputs.
	input  wire ioc_panel_t             rescue_bus,       // Rescue panel, first_field_bus unit.
	input  wire logic                   pit_reset_in,     // Dedicated pit reset input.
	input  wire logic                   passive_chain_ok, // Passive chain, safety_board.
	input  wire logic [POS_W-1:0]       car_pos,          // Car position.
	input  wire logic [POS_W-1:0]       top_floor_pos,    // Top floor level.
	input  wire logic [POS_W-1:0]       bottom_floor_pos, // Bottom floor level.
	output logic                        drive_up,         // Travel up command.
	output logic                        drive_down,       // Travel down command.
	output ioc_speed_t                  speed_sel,        // Commanded speed.
	output logic                        door_open_cmd,    // Door open, manual door mode.
	output logic                        door_close_cmd,   // Door close, manual door mode.
	output logic                        pit_buzzer,       // Pit driving buzzer.
	output logic                        lift_blocked,     // Pit block holds the lift.
	output ioc_mode_t                   mode              // Active operating mode.
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	initial begin
		if (TICK_CYCLES < 1) $error("ioc_inspection_ctrl: TICK_CYCLES below one");
		if (POS_W < 1 || POS_W > 32) $error("ioc_inspection_ctrl: POS_W out of range");
	end

	logic [`IOC_CTRL_W-1:0] ctrl;
	logic [POS_W-1:0]       top_dist;
	logic [POS_W-1:0]       bot_dist;
	logic [TICK_W-1:0]      div_cnt;
	logic                   ms_tick;
	logic                   pit_latch;
	logic                   door_mode;
	logic                   hold_done_q;
	ioc_panel_t             car_top;
	ioc_panel_t             rescue;
	ioc_panel_t             panel;
	ioc_mode_t              next_mode;
	logic                   top_on;
	logic                   pit_on;
	logic                   res_on;
	logic                   wr;
	logic                   rd_setup;
	logic                   addr_ok;
	logic                   ui_pit_reset;
	logic                   chain_ok;
	logic                   up_room;
	logic                   down_room;
	logic                   next_up;
	logic                   next_down;
	ioc_speed_t             next_speed;
	logic [POS_W:0]         up_limit;
	logic [POS_W:0]         down_limit;
	logic [31:0]            status;
	logic [31:0]            next_rdata;

	ioc_tmr_if hold_if ();
	ioc_tmr_if buzz_if ();
	ioc_tmr_if norm_if ();

	// Each panel comes from its one configured source.
	assign car_top = ctrl[`IOC_CTRL_SRC_TOP] ? car_top_bus : car_top_board; // RQ2
	assign rescue  = ctrl[`IOC_CTRL_SRC_RES] ? rescue_bus : rescue_board;   // RQ3

	// Enables are normally closed; low turns the mode on.
	assign top_on = !car_top.enable_n;   // RQ1
	assign pit_on = !pit_panel.enable_n; // RQ1
	assign res_on = !rescue.enable_n;    // RQ1

	// Car top wins over pit, pit over rescue, so the person on the car
	// keeps control.
	always_comb begin
		next_mode = IOC_MODE_NORMAL;
		panel     = '0;
		if (top_on) begin
			next_mode = IOC_MODE_CAR_TOP;
			panel     = car_top;
		end else if (pit_on) begin
			next_mode = IOC_MODE_PIT;
			panel     = pit_panel;
		end else if (res_on) begin
			next_mode = IOC_MODE_RESCUE;
			panel     = rescue;
		end
	end

	// APB decode. Reads register their data in the setup cycle so pready can stay high.
	assign wr       = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign addr_ok  = (paddr == `IOC_ADDR_CTRL) || (paddr == `IOC_ADDR_CMD)
		|| (paddr == `IOC_ADDR_TOP_DIST) || (paddr == `IOC_ADDR_BOT_DIST)
		|| (paddr == `IOC_ADDR_STATUS);
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !addr_ok;
	assign ui_pit_reset = wr && (paddr == `IOC_ADDR_CMD) && pwdata[`IOC_CMD_PIT_RST];

	// Millisecond enable for all hold times.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			ms_tick <= 1'b0;
		end else if (div_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			div_cnt <= '0;
			ms_tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + TICK_W'(1);
			ms_tick <= 1'b0;
		end
	end

	// Operating mode register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= IOC_MODE_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	// Pit latch: set while the pit panel is on, a set beats a clear.
	// The display clear needs policy consent; the reset input does not.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pit_latch <= 1'b0;
		end else if (!ctrl[`IOC_CTRL_PIT_USED]) begin
			pit_latch <= 1'b0;
		end else if (pit_on) begin
			pit_latch <= 1'b1; // RQ4
		end else if (pit_reset_in || (ui_pit_reset && ctrl[`IOC_CTRL_PIT_UI_OK])) begin
			pit_latch <= 1'b0; // RQ5
		end
	end

	// Timers: button hold, buzzer length, normal running.
	assign hold_if.tick = ms_tick;
	assign buzz_if.tick = ms_tick;
	assign norm_if.tick = ms_tick;
	assign hold_if.run  = ctrl[`IOC_CTRL_MAN_DOOR] && (next_mode == IOC_MODE_CAR_TOP)
		&& car_top.up && car_top.down; // RQ10
	assign buzz_if.run  = pit_buzzer;
	assign norm_if.run  = (next_mode == IOC_MODE_NORMAL) && ctrl[`IOC_CTRL_BEYOND];

	ioc_hold_timer #(.LIMIT(HOLD_MS), .W(`IOC_TMR_W)) u_hold (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (hold_if.timer)
	);

	ioc_hold_timer #(.LIMIT(BUZZ_MS), .W(`IOC_TMR_W)) u_buzz (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (buzz_if.timer)
	);

	ioc_hold_timer #(.LIMIT(NORMAL_CLR_MS), .W(`IOC_TMR_W)) u_norm (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (norm_if.timer)
	);

	// Door role: each completed hold toggles it; leaving car top mode
	// by toggling the switch restores direction use.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			door_mode   <= 1'b0;
			hold_done_q <= 1'b0;
		end else begin
			hold_done_q <= hold_if.done;
			if (next_mode != IOC_MODE_CAR_TOP || !ctrl[`IOC_CTRL_MAN_DOOR]) begin
				door_mode <= 1'b0; // RQ12
			end else if (hold_if.done && !hold_done_q) begin
				door_mode <= !door_mode; // RQ10 RQ12
			end
		end
	end

	// A fitted buzzer sounds from each hold-driven role change.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pit_buzzer <= 1'b0;
		end else if (hold_if.done && !hold_done_q && ctrl[`IOC_CTRL_BUZZ_FIT]
			&& next_mode == IOC_MODE_CAR_TOP) begin
			pit_buzzer <= 1'b1; // RQ11
		end else if (buzz_if.done) begin
			pit_buzzer <= 1'b0; // RQ11
		end
	end

	// Inspection keeps its stop distances from both terminal floors;
	// rescue stops at the floors unless the beyond flag is set.
	assign up_limit   = {1'b0, car_pos} + {1'b0, top_dist};
	assign down_limit = {1'b0, bottom_floor_pos} + {1'b0, bot_dist};
	always_comb begin
		up_room   = 1'b0;
		down_room = 1'b0;
		if (next_mode == IOC_MODE_RESCUE) begin
			up_room   = ctrl[`IOC_CTRL_BEYOND] || (car_pos < top_floor_pos);    // RQ9
			down_room = ctrl[`IOC_CTRL_BEYOND] || (car_pos > bottom_floor_pos); // RQ9
		end else begin
			up_room   = up_limit < {1'b0, top_floor_pos};  // RQ13
			down_room = {1'b0, car_pos} > down_limit;      // RQ13
		end
	end

	// The passive chain gates travel; rescue may be told to look past it.
	assign chain_ok = passive_chain_ok
		|| (next_mode == IOC_MODE_RESCUE && ctrl[`IOC_CTRL_RES_NOCHN]); // RQ8

	// Both or no buttons, door mode or a dead chain mean standstill;
	// an unfitted fast button gives creep speed.
	always_comb begin
		next_up    = 1'b0;
		next_down  = 1'b0;
		next_speed = IOC_SPD_STOP;
		if (next_mode != IOC_MODE_NORMAL && !door_mode && chain_ok
			&& (panel.up != panel.down)) begin
			next_up   = panel.up && up_room;
			next_down = panel.down && down_room;
		end
		if (next_up || next_down) begin
			case (next_mode)
				IOC_MODE_RESCUE: begin
					next_speed = (ctrl[`IOC_CTRL_RES_FAST] && panel.fast)
						? IOC_SPD_RESCUE : IOC_SPD_CREEP; // RQ7
				end
				IOC_MODE_CAR_TOP, IOC_MODE_PIT: begin
					next_speed = (ctrl[`IOC_CTRL_INS_FAST] && panel.fast)
						? IOC_SPD_INSPECT : IOC_SPD_CREEP; // RQ6
				end
				default: begin
					next_speed = IOC_SPD_STOP;
				end
			endcase
		end
	end

	// Registered drive and door outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_up       <= 1'b0;
			drive_down     <= 1'b0;
			speed_sel      <= IOC_SPD_STOP;
			door_open_cmd  <= 1'b0;
			door_close_cmd <= 1'b0;
			lift_blocked   <= 1'b0;
		end else begin
			drive_up       <= next_up;    // RQ15
			drive_down     <= next_down;  // RQ15
			speed_sel      <= next_speed; // RQ15
			door_open_cmd  <= door_mode && top_on && car_top.up && !car_top.down; // RQ10
			door_close_cmd <= door_mode && top_on && car_top.down && !car_top.up; // RQ10
			lift_blocked   <= pit_latch && !pit_on; // RQ4
		end
	end

	// Control register; a write beats the automatic clear of the
	// beyond flag, so a fresh setting is never lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `IOC_CTRL_W'(`IOC_CTRL_RST);
		end else if (wr && paddr == `IOC_ADDR_CTRL) begin
			ctrl <= pwdata[`IOC_CTRL_W-1:0];
		end else if (norm_if.done) begin
			ctrl[`IOC_CTRL_BEYOND] <= 1'b0; // RQ9
		end
	end

	// Stop distance registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_dist <= POS_W'(`IOC_DIST_RST);
			bot_dist <= POS_W'(`IOC_DIST_RST);
		end else if (wr) begin
			if (paddr == `IOC_ADDR_TOP_DIST) begin
				top_dist <= pwdata[POS_W-1:0]; // RQ13
			end
			if (paddr == `IOC_ADDR_BOT_DIST) begin
				bot_dist <= pwdata[POS_W-1:0]; // RQ13
			end
		end
	end

	// Live status word.
	always_comb begin
		status = '0;
		status[`IOC_ST_MODE_LO +: 2]  = mode;
		status[`IOC_ST_SPEED_LO +: 2] = speed_sel;
		status[`IOC_ST_UP]            = drive_up;
		status[`IOC_ST_DOWN]          = drive_down;
		status[`IOC_ST_PIT_LATCH]     = pit_latch;
		status[`IOC_ST_BLOCKED]       = lift_blocked;
		status[`IOC_ST_DOOR_MODE]     = door_mode;
		status[`IOC_ST_BUZZ]          = pit_buzzer;
		status[`IOC_ST_CHAIN]         = passive_chain_ok;
	end

	// Read multiplexer; unmapped and command addresses read zero.
	always_comb begin
		next_rdata = '0;
		case (paddr)
			`IOC_ADDR_CTRL: begin
				next_rdata = 32'(ctrl);
			end
			`IOC_ADDR_TOP_DIST: begin
				next_rdata = 32'(top_dist);
			end
			`IOC_ADDR_BOT_DIST: begin
				next_rdata = 32'(bot_dist);
			end
			`IOC_ADDR_STATUS: begin
				next_rdata = status;
			end
			default: begin
				next_rdata = '0;
			end
		endcase
	end

	// Read data, loaded in a read's setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			prdata <= next_rdata;
		end
	end
endmodule

// file: hw/ioc_pkg.sv
// Types shared by the inspection and rescue drive controller.
package ioc_pkg;

	typedef enum logic [1:0] {IOC_MODE_NORMAL, IOC_MODE_CAR_TOP, IOC_MODE_PIT,
		IOC_MODE_RESCUE} ioc_mode_t;

	typedef enum logic [1:0] {IOC_SPD_STOP, IOC_SPD_CREEP, IOC_SPD_INSPECT,
		IOC_SPD_RESCUE} ioc_speed_t;

	// One panel; enable_n is a normally closed contact.
	typedef struct packed {
		logic fast;
		logic down;
		logic up;
		logic enable_n;
	} ioc_panel_t;

endpackage

// file: hw/ioc_tmr_if.sv
// Interface joining the controller to one of its millisecond hold timers.
`timescale 1ns/1ps
interface ioc_tmr_if;
	logic run;  // Count while high, clear while low.
	logic tick; // One-cycle millisecond enable.
	logic done; // Limit reached.

	modport timer (input run, input tick, output done);
	modport user  (output run, output tick, input done);
endinterface

// file: test/ioc_chk.sv
// Checker watching the ports of the inspection drive controller.
`timescale 1ns/1ps
`include "ioc_cfg.svh"
module ioc_chk
	import ioc_pkg::*;
#(
	parameter int TICK_CYCLES = 4,
	parameter int BUZZ_MS     = 3
) (
	input wire logic                   pclk,           // Clock.
	input wire logic                   presetn,        // Reset, active low.
	input wire logic                   psel,           // APB select.
	input wire logic                   penable,        // APB access.
	input wire logic                   pwrite,         // APB write.
	input wire logic [`IOC_ADDR_W-1:0] paddr,          // APB address.
	input wire logic                   pit_reset_in,   // Pit reset.
	input wire ioc_panel_t             car_top_board,  // Car top, board.
	input wire ioc_panel_t             car_top_bus,    // Car top, bus.
	input wire ioc_panel_t             rescue_board,   // Rescue, board.
	input wire ioc_panel_t             rescue_bus,     // Rescue, bus.
	input wire ioc_panel_t             pit_panel,      // Pit panel.
	input wire logic                   drive_up,       // Up command.
	input wire logic                   drive_down,     // Down command.
	input wire ioc_speed_t             speed_sel,      // Speed.
	input wire logic                   door_open_cmd,  // Door open.
	input wire logic                   door_close_cmd, // Door close.
	input wire logic                   pit_buzzer,     // Buzzer.
	input wire logic                   lift_blocked,   // Pit block.
	input wire ioc_mode_t              mode            // Mode.
);
	logic [15:0] bc;
	logic        cmd_wr;

	// A display reset only counts in a completed write to the command word.
	assign cmd_wr = psel && penable && pwrite && paddr == `IOC_ADDR_CMD;

	// Counts how long the buzzer has been sounding.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bc <= '0;
		end else if (pit_buzzer) begin
			bc <= bc + 16'h0001;
		end else begin
			bc <= '0;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ct_idle;
		!car_top_board.enable_n && !car_top_board.up && !car_top_board.down &&
			!car_top_bus.up && !car_top_bus.down;
	endsequence

	AST_IDLE: assert property (s_ct_idle |=> !drive_up && !drive_down &&
		speed_sel == IOC_SPD_STOP) else $error("car top idle but moving");
	AST_CT_SRC: assert property (mode == IOC_MODE_CAR_TOP |->
		$past(!car_top_board.enable_n || !car_top_bus.enable_n)) else $error("car top no cause");
	AST_RES_SRC: assert property (mode == IOC_MODE_RESCUE |->
		$past(!rescue_board.enable_n || !rescue_bus.enable_n)) else $error("rescue no cause");
	AST_ONE_DIR: assert property (!(drive_up && drive_down))
		else $error("both directions");
	AST_MOVE_SPEED: assert property ((drive_up || drive_down) |->
		speed_sel != IOC_SPD_STOP) else $error("travel without speed");
	AST_NORMAL_STILL: assert property (mode == IOC_MODE_NORMAL |->
		!drive_up && !drive_down) else $error("normal mode travel");
	AST_DOOR_CT: assert property ((door_open_cmd || door_close_cmd) |->
		mode == IOC_MODE_CAR_TOP && !drive_up && !drive_down) else $error("door cmd misplaced");
	AST_BUZZ_LEN: assert property ($fell(pit_buzzer) |->
		bc >= (BUZZ_MS - 1) * TICK_CYCLES && bc <= (BUZZ_MS + 1) * TICK_CYCLES)
		else $error("buzzer length wrong");
	AST_PIT_HOLD: assert property (lift_blocked && pit_panel.enable_n &&
		!pit_reset_in && !$past(pit_reset_in) && !cmd_wr && !$past(cmd_wr) |=> lift_blocked)
		else $error("pit block lost");
endmodule

bind ioc_inspection_ctrl ioc_chk #(.TICK_CYCLES(TICK_CYCLES), .BUZZ_MS(BUZZ_MS)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pit_reset_in(pit_reset_in), .car_top_board(car_top_board),
	.car_top_bus(car_top_bus), .rescue_board(rescue_board), .rescue_bus(rescue_bus),
	.pit_panel(pit_panel), .drive_up(drive_up), .drive_down(drive_down),
	.speed_sel(speed_sel), .door_open_cmd(door_open_cmd), .door_close_cmd(door_close_cmd),
	.pit_buzzer(pit_buzzer), .lift_blocked(lift_blocked), .mode(mode));

// file: test/ioc_panel_model.sv
// Model of the technician's pushbutton panels and the wired safety chain.
`timescale 1ns/1ps
module ioc_panel_model
	import ioc_pkg::*;
(
	input  wire logic [1:0] sel,      // Panel on: 0 none, 1 top, 2 pit, 3 rescue.
	input  wire logic       on_bus,   // Top or rescue panel sits on the field bus.
	input  wire logic [2:0] btn,      // Fast, down, up.
	input  wire logic       fault,    // Extra open contact in the chain.
	output ioc_panel_t      ct_b,     // Car top, board.
	output ioc_panel_t      ct_f,     // Car top, bus.
	output ioc_panel_t      pit,      // Pit.
	output ioc_panel_t      rs_b,     // Rescue, board.
	output ioc_panel_t      rs_f,     // Rescue, bus.
	output logic            chain_ok  // Passive chain closed.
);
	// A panel that is off shows its closed enable contact and pulled-down buttons.
	function automatic ioc_panel_t pan(input logic on);
		pan = on ? {btn, 1'b0} : 4'b0001;
	endfunction

	// Each panel set is wired to one source only.
	assign ct_b = pan(sel == 2'd1 && !on_bus);
	assign ct_f = pan(sel == 2'd1 && on_bus);
	assign pit = pan(sel == 2'd2);
	assign rs_b = pan(sel == 2'd3 && !on_bus);
	assign rs_f = pan(sel == 2'd3 && on_bus);

	// The switch opens the chain; a direction button closes it again.
	assign chain_ok = !fault && (sel == 2'd0 || btn[1:0] != 2'b00);
endmodule

// file: test/testbench.sv
// Self-checking bench for the inspection drive controller.
`timescale 1ns/1ps
`include "ioc_cfg.svh"
module testbench
	import ioc_pkg::*;
;
	localparam int TK = 4;
	localparam int HM = 5;
	localparam int NC = 6;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [23:0] car_pos, top_pos, bot_pos;
	logic [1:0]  sel;
	logic [2:0]  btn;
	logic        on_bus, fault, pit_rst, chain_ok, du, dd, dop, dcl, buzz, blk;
	ioc_panel_t  ctb, ctf, pit, rsb, rsf;
	ioc_speed_t  spd;
	ioc_mode_t   md;
	int          miscompares, n_compared, n;

	ioc_panel_model pm (.sel(sel), .on_bus(on_bus), .btn(btn), .fault(fault), .ct_b(ctb),
		.ct_f(ctf), .pit(pit), .rs_b(rsb), .rs_f(rsf), .chain_ok(chain_ok));

	ioc_inspection_ctrl #(.TICK_CYCLES(TK), .HOLD_MS(HM), .BUZZ_MS(3), .NORMAL_CLR_MS(NC)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.car_top_board(ctb), .car_top_bus(ctf), .pit_panel(pit), .rescue_board(rsb),
		.rescue_bus(rsf), .pit_reset_in(pit_rst), .passive_chain_ok(chain_ok),
		.car_pos(car_pos), .top_floor_pos(top_pos), .bottom_floor_pos(bot_pos),
		.drive_up(du), .drive_down(dd), .speed_sel(spd), .door_open_cmd(dop),
		.door_close_cmd(dcl), .pit_buzzer(buzz), .lift_blocked(blk), .mode(md));

	// Free-running 200 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic print_verdict();
		if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; only the watchdog ends a wait.
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_n(int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask

	task automatic pan(logic [1:0] s, logic [2:0] b, logic ob = 1'b0, logic f = 1'b0);
		@(posedge pclk);
		sel <= s;
		btn <= b;
		on_bus <= ob;
		fault <= f;
		wait_n(3);
	endtask

	task automatic pos(logic [23:0] v);
		@(posedge pclk);
		car_pos <= v;
		wait_n(3);
	endtask

	task automatic look(string nm, logic u, logic d, ioc_speed_t s, ioc_mode_t m);
		chk({nm, " up"}, 32'(du), 32'(u));
		chk({nm, " down"}, 32'(dd), 32'(d));
		chk({nm, " speed"}, 32'(spd), 32'(s));
		chk({nm, " mode"}, 32'(md), 32'(m));
	endtask

	task automatic t_regs();
		apb(1'b0, `IOC_ADDR_CTRL, 32'h0);
		chk("ctrl reset", rd, `IOC_CTRL_RST);
		apb(1'b0, 12'h0f0, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask

	task automatic t_car_top();
		pan(2'd1, 3'b001);
		look("ct creep", 1'b1, 1'b0, IOC_SPD_CREEP, IOC_MODE_CAR_TOP);
		apb(1'b1, `IOC_ADDR_CTRL, 32'h4);
		pan(2'd1, 3'b101);
		look("ct fast", 1'b1, 1'b0, IOC_SPD_INSPECT, IOC_MODE_CAR_TOP);
		pan(2'd1, 3'b010);
		look("ct down", 1'b0, 1'b1, IOC_SPD_CREEP, IOC_MODE_CAR_TOP);
		pan(2'd1, 3'b000);
		look("ct idle", 1'b0, 1'b0, IOC_SPD_STOP, IOC_MODE_CAR_TOP);
		pan(2'd2, 3'b001);
		look("pit up", 1'b1, 1'b0, IOC_SPD_CREEP, IOC_MODE_PIT);
	endtask

	// Each panel is heard only from the source its select bit names.
	task automatic t_src();
		apb(1'b1, `IOC_ADDR_CTRL, 32'h100);
		pan(2'd1, 3'b001);
		look("ct board off", 1'b0, 1'b0, IOC_SPD_STOP, IOC_MODE_NORMAL);
		pan(2'd1, 3'b001, 1'b1);
		look("ct bus", 1'b1, 1'b0, IOC_SPD_CREEP, IOC_MODE_CAR_TOP);
		pan(2'd3, 3'b010, 1'b1);
		look("res bus off", 1'b0, 1'b0, IOC_SPD_STOP, IOC_MODE_NORMAL);
		pan(2'd3, 3'b010);
		look("res board", 1'b0, 1'b1, IOC_SPD_CREEP, IOC_MODE_RESCUE);
	endtask

	task automatic t_rescue();
		apb(1'b1, `IOC_ADDR_CTRL, 32'h8);
		pan(2'd3, 3'b110);
		look("res fast", 1'b0, 1'b1, IOC_SPD_RESCUE, IOC_MODE_RESCUE);
		pan(2'd3, 3'b110, 1'b0, 1'b1);
		look("res chain", 1'b0, 1'b0, IOC_SPD_STOP, IOC_MODE_RESCUE);
		apb(1'b1, `IOC_ADDR_CTRL, 32'h18);
		wait_n(3);
		look("res ignore", 1'b0, 1'b1, IOC_SPD_RESCUE, IOC_MODE_RESCUE);
	endtask

	// Stop distances: the boundary position is refused, one step inside is allowed.
	task automatic t_limits();
		apb(1'b1, `IOC_ADDR_CTRL, 32'h0);
		apb(1'b1, `IOC_ADDR_TOP_DIST, 32'd100);
		apb(1'b1, `IOC_ADDR_BOT_DIST, 32'd50);
		pos(24'd900);
		pan(2'd1, 3'b001);
		chk("top stop", 32'(du), 32'h0);
		pos(24'd899);
		chk("top go", 32'(du), 32'h1);
		pos(24'd150);
		pan(2'd1, 3'b010);
		chk("bot stop", 32'(dd), 32'h0);
		pos(24'd151);
		chk("bot go", 32'(dd), 32'h1);
	endtask

	task automatic t_beyond();
		pos(24'd1000);
		pan(2'd3, 3'b001);
		chk("res top stop", 32'(du), 32'h0);
		apb(1'b1, `IOC_ADDR_CTRL, 32'h20);
		wait_n(3);
		chk("res beyond", 32'(du), 32'h1);
		pan(2'd0, 3'b000);
		wait_n(NC * TK + 10);
		apb(1'b0, `IOC_ADDR_CTRL, 32'h0);
		chk("beyond cleared", rd, 32'h0);
		pos(24'd500);
	endtask

	task automatic t_pit();
		apb(1'b1, `IOC_ADDR_CTRL, 32'h1);
		pan(2'd2, 3'b000);
		pan(2'd0, 3'b000);
		chk("pit blocked", 32'(blk), 32'h1);
		apb(1'b1, `IOC_ADDR_CMD, 32'h1);
		wait_n(3);
		chk("pit ui refused", 32'(blk), 32'h1);
		@(posedge pclk);
		pit_rst <= 1'b1;
		wait_n(2);
		@(posedge pclk);
		pit_rst <= 1'b0;
		wait_n(3);
		chk("pit input clear", 32'(blk), 32'h0);
		apb(1'b1, `IOC_ADDR_CTRL, 32'h3);
		pan(2'd2, 3'b000);
		pan(2'd0, 3'b000);
		apb(1'b1, `IOC_ADDR_CMD, 32'h1);
		wait_n(3);
		chk("pit ui clear", 32'(blk), 32'h0);
	endtask

	task automatic t_door();
		apb(1'b1, `IOC_ADDR_CTRL, 32'hc0);
		pan(2'd1, 3'b011);
		n = 0;
		while (buzz !== 1'b1 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		chk("hold time", 32'(n >= HM * TK - TK - 3 && n <= HM * TK + TK), 32'h1);
		pan(2'd1, 3'b000);
		pan(2'd1, 3'b001);
		chk("door open", 32'({dop, du}), 32'h2);
		pan(2'd1, 3'b010);
		chk("door close", 32'({dcl, dd}), 32'h2);
		pan(2'd0, 3'b000);
		pan(2'd1, 3'b001);
		chk("toggle back", 32'({dop, du}), 32'h1);
	endtask

	// Idle inputs, six cycles of reset, then the scenarios.
	initial begin
		miscompares = 0;
		n_compared = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		sel = 2'd0;
		btn = 3'b000;
		on_bus = 1'b0;
		fault = 1'b0;
		pit_rst = 1'b0;
		car_pos = 24'd500;
		top_pos = 24'd1000;
		bot_pos = 24'd100;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_car_top();
		t_src();
		t_rescue();
		t_limits();
		t_beyond();
		t_pit();
		t_door();
		print_verdict();
	end

	// Watchdog: the scenarios need a few hundred cycles.
	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
endmodule
